// *** rtl/acop_fifo.sv ***
// Result FIFO between the converter and the output word register.
`timescale 1ns/10ps
module acop_fifo
  import acop_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_WIDTH = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_WIDTH-1:0] wr_ptr, next_wr_ptr;
  logic [PTR_WIDTH-1:0] rd_ptr, next_rd_ptr;
  logic [PTR_WIDTH:0] count, next_count;
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count != (PTR_WIDTH+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update; pointers wrap at the depth.
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == PTR_WIDTH'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == PTR_WIDTH'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  // State registers; the storage array needs no reset.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// *** rtl/acop_pkg.sv ***
// Shared constants and types of the converter control and output port.
package acop_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int DATA_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACQ_TIME_NS = 1250;
  localparam int CONV_TIME_NS = 8000;
  // Least times, so both round up to whole cycles.
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_WIDTH = 16;
  localparam int SCLK_HALF_CYCLES = 2;
  localparam logic [2:0] OVERRUN_PULSE_CYCLES = 3'h4;
  localparam logic [4:0] LAST_BIT_INDEX = 5'h0f;
  localparam logic [4:0] LINK_DONE_INDEX = 5'h10;

  // ----------------------------------------------------------------------
  // Shared pin positions on the data bus
  // ----------------------------------------------------------------------
  localparam int PIN_SERIAL_DATA = 8;
  localparam int PIN_SERIAL_CLOCK = 9;
  localparam int PIN_FRAME_SYNC = 10;
  localparam int PIN_OVERRUN = 11;
  localparam int PIN_UPPER_LSB = 12;
  localparam int PIN_SERIAL_LAST = 11;

  // ----------------------------------------------------------------------
  // Positions in the input synchroniser vector
  // ----------------------------------------------------------------------
  localparam int SYNC_WIDTH = 9;
  localparam int SY_SER = 0;
  localparam int SY_EXT = 1;
  localparam int SY_INV_SYNC = 2;
  localparam int SY_PD = 3;
  localparam int SY_CNV_N = 4;
  localparam int SY_CS_N = 5;
  localparam int SY_RD_N = 6;
  localparam int SY_STARTED = 7;
  localparam int SY_DONE = 8;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    CONV_ACQUIRE = 5'h01,
    CONV_WAIT_START = 5'h02,
    CONV_CONVERT = 5'h04,
    CONV_LATCH = 5'h08,
    CONV_POWER_DOWN = 5'h10
  } acop_conv_state_type;

  typedef enum logic [1:0] {
    MSHIFT_IDLE = 2'h1,
    MSHIFT_RUN = 2'h2
  } acop_master_state_type;

endpackage

// *** rtl/acop_serial_link.sv ***
// Externally clocked serial shifter that runs on the host's serial clock.
`timescale 1ns/10ps
module acop_serial_link
  import acop_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH
)
(
  // Link clock from the shared pin and its strap
  input wire logic serial_clock_in,
  input wire logic serial_clock_invert,
  // Frame gate from the host
  input wire logic chip_select_n,
  // Word from the system domain, which can load a new one while a frame runs
  input wire logic [WIDTH-1:0] word,
  // Link outputs
  output logic serial_bit,
  output logic read_started,
  output logic read_done
);

  logic link_clk;
  logic [4:0] bit_index, next_bit_index;
  logic next_started, next_done;

  // The invert input is a static strap, so folding it into the clock
  // selects the update edge without a second set of flops.
  assign link_clk = serial_clock_in ^ serial_clock_invert;

  // Count active edges; the index saturates once all bits are out.
  always_comb
  begin
    next_bit_index = (bit_index == LINK_DONE_INDEX) ? bit_index : bit_index + 1'b1;
    next_started = 1'b1;
    next_done = (next_bit_index == LINK_DONE_INDEX);
  end

  // The clock stops between frames, so chip select itself ends the frame.
  always_ff @(posedge link_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      bit_index <= '0;
      read_started <= 1'b0;
      read_done <= 1'b0;
    end
    else
    begin
      bit_index <= next_bit_index;
      read_started <= next_started;
      read_done <= next_done;
    end
  end

  // The MSB stands before and after the first edge, and each later edge shows the next one.
  assign serial_bit = (bit_index == '0) ? word[WIDTH-1] : word[WIDTH - 32'(bit_index)];

endmodule

// *** rtl/acop_top.sv ***
// Conversion control and parallel or serial output port of the converter.
//
// Overview of operation
// - Serial mode: bit-9 pin is clock input if external, output if internal.
// - Clock-invert input selects the serial clock edge that updates data; internal clock ignores it, updates on falling edge.
// - Internal clocking: frame sync active during read; polarity set by sync-invert.
// - External clocking: unfinished read at next conversion end discards, pulses overrun.
// - Bus bits twelve to fifteen are outputs in every mode.
// - Parallel mode: shared pins carry data bits nine, ten and eleven.
// - Busy rises at conversion start, falls once result sits in output register.
// - Output drivers enabled only while chip select and read are both low.
// - Chip select gates the external serial clock.
// - Reset returns to reset state and aborts any conversion.
// - Power-down finishes the current conversion, then inhibits further ones.
// - Start high at acquisition end: wait for its falling edge, then convert.
// - Start already low at acquisition end: hold and convert at once.
// - Serial result leaves MSB first.
// - External clock: invert low updates on rising edge, high on falling.
`timescale 1ns/10ps
module acop_top
  import acop_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Mode and control pins
  input wire logic serial_parallel_select,
  input wire logic external_clock_select,
  input wire logic serial_clock_invert,
  input wire logic frame_sync_invert,
  input wire logic power_down_request,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  // Serial clock from the bit-9 pin when clocked externally
  input wire logic serial_clock_in,
  // Result of the successive-approximation core
  input wire logic [WIDTH-1:0] conversion_code,
  // Converter status
  output logic sample_hold,
  output logic busy,
  output logic power_saving,
  // Data bus pins
  output logic [WIDTH-1:0] data_bus_out,
  output logic [WIDTH-1:0] data_bus_oe
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] sync_raw, sync_meta, sync_q;
  logic link_started, link_done, link_bit;
  logic ser_s, ext_s, inv_sync_s, pd_s, cnv_n_s, bus_en;

  assign sync_raw = {link_done, link_started, read_n, chip_select_n, convert_start_n,
                     power_down_request, frame_sync_invert, external_clock_select,
                     serial_parallel_select};

  // Two flops for each mode and control pin but the clock-invert strap, and each level from the link domain.
  always_ff @(posedge clk)
  begin
    sync_meta <= sync_raw;
    sync_q <= sync_meta;
  end

  assign ser_s = sync_q[SY_SER];
  assign ext_s = sync_q[SY_EXT];
  assign inv_sync_s = sync_q[SY_INV_SYNC];
  assign pd_s = sync_q[SY_PD];
  assign cnv_n_s = sync_q[SY_CNV_N];
  assign bus_en = !sync_q[SY_CS_N] && !sync_q[SY_RD_N];

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  acop_conv_state_type conv_state, next_conv_state;
  logic [COUNT_WIDTH-1:0] conv_count, next_conv_count;
  logic [WIDTH-1:0] conv_result, next_conv_result;
  logic cnv_prev, push, fifo_in_ready, cnv_fall;

  assign cnv_fall = cnv_prev && !cnv_n_s;

  // Power-down is looked at only between conversions, so a running one ends.
  always_comb
  begin
    next_conv_state = conv_state;
    next_conv_count = conv_count;
    next_conv_result = conv_result;
    push = 1'b0;
    case (conv_state)
      CONV_ACQUIRE:
      begin
        if (conv_count == COUNT_WIDTH'(ACQ_CYCLES - 1))
        begin
          next_conv_count = '0;
          if (pd_s)
          begin
            next_conv_state = CONV_POWER_DOWN;
          end
          else if (!cnv_n_s)
          begin
            next_conv_state = CONV_CONVERT;
          end
          else
          begin
            next_conv_state = CONV_WAIT_START;
          end
        end
        else
        begin
          next_conv_count = conv_count + 1'b1;
        end
      end
      CONV_WAIT_START:
      begin
        if (pd_s)
        begin
          next_conv_state = CONV_POWER_DOWN;
        end
        else if (cnv_fall)
        begin
          next_conv_state = CONV_CONVERT;
        end
      end
      CONV_CONVERT:
      begin
        if (conv_count == COUNT_WIDTH'(CONV_CYCLES - 1))
        begin
          next_conv_count = '0;
          next_conv_result = conversion_code;
          next_conv_state = CONV_LATCH;
        end
        else
        begin
          next_conv_count = conv_count + 1'b1;
        end
      end
      CONV_LATCH:
      begin
        // A full FIFO stalls the sequencer here rather than lose a result.
        push = 1'b1;
        if (fifo_in_ready)
        begin
          next_conv_state = CONV_ACQUIRE;
        end
      end
      CONV_POWER_DOWN:
      begin
        if (!pd_s)
        begin
          next_conv_state = CONV_ACQUIRE;
        end
      end
      default:
      begin
        next_conv_state = CONV_ACQUIRE;
      end
    endcase
  end

  // Reset drops any conversion in flight and restarts acquisition.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      conv_state <= CONV_ACQUIRE;
      conv_count <= '0;
      conv_result <= '0;
      cnv_prev <= 1'b1;
    end
    else
    begin
      conv_state <= next_conv_state;
      conv_count <= next_conv_count;
      conv_result <= next_conv_result;
      cnv_prev <= cnv_n_s;
    end
  end

  assign sample_hold = (conv_state == CONV_CONVERT);
  assign power_saving = (conv_state == CONV_POWER_DOWN);

  // ----------------------------------------------------------------------
  // Result FIFO and output word register
  // ----------------------------------------------------------------------
  logic fifo_out_valid, pop, master_busy, master_start, overrun_hit;
  logic [WIDTH-1:0] fifo_out_data, out_word, next_out_word;
  logic busy_pending, next_busy_pending, word_fresh, next_word_fresh;
  logic [2:0] overrun_count, next_overrun_count;

  acop_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(conv_result),
    .out_valid(fifo_out_valid),
    .out_ready(!master_busy && !master_start),
    .out_data(fifo_out_data)
  );

  // An internal read in progress or starting holds the word; a slave read does not.
  // A load in the start cycle would mix two words in one internal read.
  assign pop = fifo_out_valid && !master_busy && !master_start;
  assign overrun_hit = pop && ser_s && ext_s && sync_q[SY_STARTED] && !sync_q[SY_DONE];

  // Loading the next word ends busy; a new push in the same cycle wins.
  always_comb
  begin
    next_out_word = out_word;
    next_busy_pending = busy_pending;
    next_word_fresh = word_fresh;
    next_overrun_count = (overrun_count != '0) ? overrun_count - 1'b1 : overrun_count;
    if (master_start)
    begin
      next_word_fresh = 1'b0;
    end
    if (pop)
    begin
      next_out_word = fifo_out_data;
      next_busy_pending = 1'b0;
      next_word_fresh = 1'b1;
    end
    if (overrun_hit)
    begin
      next_overrun_count = OVERRUN_PULSE_CYCLES;
    end
    if (push && fifo_in_ready)
    begin
      next_busy_pending = 1'b1;
    end
  end

  // Output word state.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_word <= '0;
      busy_pending <= 1'b0;
      word_fresh <= 1'b0;
      overrun_count <= '0;
    end
    else
    begin
      out_word <= next_out_word;
      busy_pending <= next_busy_pending;
      word_fresh <= next_word_fresh;
      overrun_count <= next_overrun_count;
    end
  end

  assign busy = sample_hold || (conv_state == CONV_LATCH) || busy_pending;

  // ----------------------------------------------------------------------
  // Internally clocked serial read
  // ----------------------------------------------------------------------
  acop_master_state_type m_state, next_m_state;
  logic [7:0] div_count, next_div_count;
  logic [4:0] bit_index, next_bit_index;
  logic sclk_out, next_sclk_out, m_bit, next_m_bit;

  // Picks a bit of a word counting from the MSB.
  function automatic logic msb_bit(input logic [WIDTH-1:0] w, input logic [4:0] idx);
    msb_bit = w[WIDTH - 1 - 32'(idx)];
  endfunction

  assign master_busy = (m_state == MSHIFT_RUN);
  assign master_start = (m_state == MSHIFT_IDLE) && ser_s && !ext_s && bus_en && word_fresh;

  // Data changes with the falling clock edge, so it is steady at each rising edge.
  always_comb
  begin
    next_m_state = m_state;
    next_div_count = div_count;
    next_bit_index = bit_index;
    next_sclk_out = sclk_out;
    next_m_bit = m_bit;
    case (m_state)
      MSHIFT_IDLE:
      begin
        next_sclk_out = 1'b0;
        if (master_start)
        begin
          next_m_state = MSHIFT_RUN;
          next_div_count = '0;
          next_bit_index = '0;
          next_m_bit = msb_bit(out_word, 5'h00);
        end
      end
      MSHIFT_RUN:
      begin
        if (div_count == 8'(SCLK_HALF_CYCLES - 1))
        begin
          next_div_count = '0;
          next_sclk_out = !sclk_out;
          if (sclk_out && (bit_index == LAST_BIT_INDEX))
          begin
            next_m_state = MSHIFT_IDLE;
          end
          else if (sclk_out)
          begin
            next_bit_index = bit_index + 1'b1;
            next_m_bit = msb_bit(out_word, bit_index + 1'b1);
          end
        end
        else
        begin
          next_div_count = div_count + 1'b1;
        end
      end
      default:
      begin
        next_m_state = MSHIFT_IDLE;
      end
    endcase
  end

  // Internal read state.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      m_state <= MSHIFT_IDLE;
      div_count <= '0;
      bit_index <= '0;
      sclk_out <= 1'b0;
      m_bit <= 1'b0;
    end
    else
    begin
      m_state <= next_m_state;
      div_count <= next_div_count;
      bit_index <= next_bit_index;
      sclk_out <= next_sclk_out;
      m_bit <= next_m_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Externally clocked read and pin assembly
  // ----------------------------------------------------------------------
  acop_serial_link #(.WIDTH(WIDTH)) u_link (
    .serial_clock_in(serial_clock_in),
    .serial_clock_invert(serial_clock_invert),
    .chip_select_n(chip_select_n),
    .word(out_word),
    .serial_bit(link_bit),
    .read_started(link_started),
    .read_done(link_done)
  );

  logic [WIDTH-1:0] bus_q, next_bus, oe_q, next_oe;

  // Drivers are enabled only while the host selects and reads.
  always_comb
  begin
    next_bus = out_word;
    next_oe = {WIDTH{bus_en}};
    if (ser_s)
    begin
      next_oe[PIN_SERIAL_DATA-1:0] = '0;
      next_bus[PIN_SERIAL_DATA] = m_bit;
      next_bus[PIN_SERIAL_CLOCK] = sclk_out;
      next_oe[PIN_SERIAL_CLOCK] = bus_en && !ext_s;
      next_bus[PIN_FRAME_SYNC] = !ext_s && (master_busy ^ inv_sync_s);
      next_bus[PIN_OVERRUN] = ext_s && (overrun_count != '0);
    end
  end

  // Pin registers.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus_q <= '0;
      oe_q <= '0;
    end
    else
    begin
      bus_q <= next_bus;
      oe_q <= next_oe;
    end
  end

  // The link bit bypasses the system flops, being timed by the host clock.
  assign data_bus_out = {bus_q[WIDTH-1:PIN_SERIAL_CLOCK],
                         (ser_s && ext_s) ? link_bit : bus_q[PIN_SERIAL_DATA],
                         bus_q[PIN_SERIAL_DATA-1:0]};
  assign data_bus_oe = oe_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  busy_on_start_a: assert property ($rose(sample_hold) |-> busy ##1 busy)
    else $error("busy not high at conversion start");
  start_at_once_a: assert property ((conv_state == CONV_ACQUIRE) &&
      (conv_count == COUNT_WIDTH'(ACQ_CYCLES - 1)) && !pd_s && !cnv_n_s |=> sample_hold)
    else $error("low start did not convert at once");
  start_on_edge_a: assert property ((conv_state == CONV_WAIT_START) && !pd_s &&
      !cnv_fall |=> !sample_hold)
    else $error("conversion began without a start edge");
  pd_inhibit_a: assert property (power_saving && pd_s |=> power_saving && !busy)
    else $error("conversion while powered down");
  reset_abort_a: assert property (@(posedge clk) reset |=> !sample_hold && !busy)
    else $error("reset did not abort conversion");
  oe_gate_a: assert property ((data_bus_oe != '0) |-> $past(bus_en))
    else $error("drivers on without select and read");
  upper_out_a: assert property ($past(bus_en) |-> (&data_bus_oe[WIDTH-1:PIN_UPPER_LSB]))
    else $error("upper bus bits not driven");
  par_pins_a: assert property ($past(bus_en && !ser_s) |->
      data_bus_out[PIN_SERIAL_LAST:PIN_SERIAL_CLOCK] ==
      $past(out_word[PIN_SERIAL_LAST:PIN_SERIAL_CLOCK]))
    else $error("parallel pins carry wrong bits");
  clk_dir_a: assert property ($past(ser_s && ext_s) |-> !data_bus_oe[PIN_SERIAL_CLOCK])
    else $error("clock pin driven in external mode");
  sync_level_a: assert property ($past(ser_s && !ext_s) |->
      data_bus_out[PIN_FRAME_SYNC] == $past(master_busy ^ inv_sync_s))
    else $error("frame sync at wrong level");
  overrun_pulse_a: assert property (overrun_hit |=> (overrun_count != '0) [*4])
    else $error("overrun flag pulse too short");
  msb_first_a: assert property (master_start |=> m_bit == $past(out_word[WIDTH-1]))
    else $error("serial read not MSB first");

  edge_start_c: cover property ((conv_state == CONV_WAIT_START) ##1 sample_hold);
  once_start_c: cover property ((conv_state == CONV_ACQUIRE) ##1 sample_hold);
  overrun_c: cover property (overrun_hit);
  master_read_c: cover property (master_start ##[1:200] !master_busy);

endmodule

// *** sim/acop_host_model.sv ***
// Host model that reads results in parallel, slave serial and master serial.
`timescale 1ns/10ps
module acop_host_model
  import acop_pkg::*;
(
  // System clock
  input wire logic clk,
  // Pins seen by the host
  input wire logic serial_clock_invert,
  input wire logic [DATA_WIDTH-1:0] data_bus_out,
  input wire logic [DATA_WIDTH-1:0] data_bus_oe,
  // Pins driven by the host
  output logic chip_select_n = 1'b1,
  output logic read_n = 1'b1,
  output logic serial_clock_in = 1'b0
);
  logic [DATA_WIDTH-1:0] got = '0;
  logic [DATA_WIDTH-1:0] oe_seen = '0;
  logic [DATA_WIDTH-1:0] sync_seen = '0;
  event done;
  logic [DATA_WIDTH-1:0] pins;

  // A pin whose driver is off reads as the inverse of its last value.
  assign pins = data_bus_out ^ ~data_bus_oe;

  // Selection and release both happen just after a system edge.
  task automatic select_bus();
    @(posedge clk);
    chip_select_n <= 1'b0;
    read_n <= 1'b0;
  endtask

  task automatic release_bus();
    @(posedge clk);
    chip_select_n <= 1'b1;
    read_n <= 1'b1;
  endtask

  // Parallel read of the whole word.
  task automatic par_read();
    select_bus();
    repeat (6) @(posedge clk);
    got = pins;
    oe_seen = data_bus_oe;
    release_bus();
    -> done;
  endtask

  // Slave read: the link clock only runs inside the frame, idle at its strap level.
  task automatic slave_read(input int n);
    serial_clock_in = serial_clock_invert;
    select_bus();
    #207;
    got = '0;
    repeat (n)
    begin
      #80 serial_clock_in = ~serial_clock_invert;
      #80 serial_clock_in = serial_clock_invert;
      got = {got[DATA_WIDTH-2:0], pins[PIN_SERIAL_DATA]};
    end
    oe_seen = data_bus_oe;
    if (n == DATA_WIDTH)
    begin
      release_bus();
      -> done;
    end
  endtask

  // Master read: data and frame sync are taken at each rising pin clock.
  task automatic master_read();
    select_bus();
    got = '0;
    repeat (DATA_WIDTH)
    begin
      @(posedge data_bus_out[PIN_SERIAL_CLOCK]);
      got = {got[DATA_WIDTH-2:0], pins[PIN_SERIAL_DATA]};
      sync_seen = {sync_seen[DATA_WIDTH-2:0], pins[PIN_FRAME_SYNC]};
    end
    oe_seen = data_bus_oe;
    @(posedge clk);
    release_bus();
    -> done;
  endtask
endmodule

// *** sim/acop_top_tb_top.sv ***
// Self-checking bench of the converter control and output port.
`timescale 1ns/10ps
module acop_top_tb_top;
  import acop_pkg::*;
  logic clk = 1'b0, reset = 1'b1, pd_req = 1'b0, start_n = 1'b1;
  logic ser_sel = 1'b0, ext_sel = 1'b0, clk_inv = 1'b0, sync_inv = 1'b0;
  logic cs_n, rd_n, sclk, sample_hold, busy, power_saving;
  logic [DATA_WIDTH-1:0] code = '0, bus_out, bus_oe, want;
  logic [DATA_WIDTH-1:0] exp_q[$];
  logic [31:0] rnd = 32'h0cfc;
  int n_mismatch = 0, n_checks = 0, n;

  // System clock, 25 ns period.
  always #12.5 clk = ~clk;

  acop_top u_acop_top (.clk(clk), .reset(reset), .serial_parallel_select(ser_sel),
    .external_clock_select(ext_sel), .serial_clock_invert(clk_inv),
    .frame_sync_invert(sync_inv), .power_down_request(pd_req), .convert_start_n(start_n),
    .chip_select_n(cs_n), .read_n(rd_n), .serial_clock_in(sclk), .conversion_code(code),
    .sample_hold(sample_hold), .busy(busy), .power_saving(power_saving),
    .data_bus_out(bus_out), .data_bus_oe(bus_oe));

  acop_host_model u_acop_host_model (.clk(clk), .serial_clock_invert(clk_inv),
    .data_bus_out(bus_out), .data_bus_oe(bus_oe), .chip_select_n(cs_n), .read_n(rd_n),
    .serial_clock_in(sclk));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [DATA_WIDTH-1:0] got, input logic [DATA_WIDTH-1:0] ref_v);
    n_checks++;
    if (got !== ref_v)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, ref_v);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Waits at falling edges, at most lim of them, for busy to reach level v.
  task automatic wait_busy(input logic v, input int lim);
    int k;
    k = 0;
    while (busy !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    check({15'h0, busy}, {15'h0, v});
  endtask

  // One conversion of a fresh random code; the hold time is counted on the way.
  task automatic convert(input int lim, input bit keep);
    int held;
    held = 0;
    rnd = lfsr_next(rnd);
    @(posedge clk);
    code <= rnd[DATA_WIDTH-1:0];
    start_n <= 1'b0;
    wait_busy(1'b1, lim);
    while (busy === 1'b1 && held < 500)
    begin
      held += int'(sample_hold);
      @(negedge clk);
    end
    check(held[15:0], 16'(CONV_CYCLES));
    @(posedge clk);
    start_n <= 1'b1;
    if (keep)
      exp_q.push_back(rnd[DATA_WIDTH-1:0]);
  endtask

  // Each word the host completes is compared with the oldest expected one.
  initial
  forever
  begin
    @(u_acop_host_model.done);
    want = exp_q.pop_front();
    check(u_acop_host_model.got, want);
  end

  // Hang guard, far above the roughly 5300 cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        repeat (100) @(negedge clk);
      convert((i == 3) ? 6 : 60, 1'b1);
      u_acop_host_model.par_read();
      check(u_acop_host_model.oe_seen, '1);
      repeat (6) @(negedge clk);
      check(bus_oe, '0);
    end
    fork
      convert(60, 1'b1);
      begin
        repeat (100) @(posedge clk);
        pd_req <= 1'b1;
      end
    join
    u_acop_host_model.par_read();
    repeat (60) @(negedge clk);
    check({15'h0, power_saving}, 16'h1);
    @(posedge clk);
    start_n <= 1'b0;
    repeat (200) @(negedge clk);
    wait_busy(1'b0, 0);
    @(posedge clk);
    pd_req <= 1'b0;
    convert(100, 1'b1);
    u_acop_host_model.par_read();
    @(posedge clk);
    start_n <= 1'b0;
    wait_busy(1'b1, 60);
    repeat (100) @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    start_n <= 1'b1;
    @(negedge clk);
    check({14'h0, busy, sample_hold}, 16'h0);
    @(posedge clk);
    ser_sel <= 1'b1;
    ext_sel <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      clk_inv <= i[0];
      convert(60, 1'b1);
      u_acop_host_model.slave_read(DATA_WIDTH);
      check({12'h0, u_acop_host_model.oe_seen[15:12]}, 16'hf);
    end
    convert(60, 1'b0);
    u_acop_host_model.slave_read(8);
    convert(60, 1'b1);
    n = 0;
    while (bus_out[PIN_OVERRUN] !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check({15'h0, bus_out[PIN_OVERRUN]}, 16'h1);
    u_acop_host_model.release_bus();
    u_acop_host_model.slave_read(DATA_WIDTH);
    @(posedge clk);
    ext_sel <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      sync_inv <= i[0];
      convert(60, 1'b1);
      u_acop_host_model.master_read();
      check(u_acop_host_model.sync_seen, {DATA_WIDTH{~i[0]}});
    end
    // Let the watcher take the last word before the run ends.
    @(posedge clk);
    check(16'(exp_q.size()), 16'h0);
    end_of_test();
  end
endmodule
